/* File: vio_pkg.sv */
// Shared constants for the bus board parallel and control-line block
package vio_pkg;
	// On-board locations (low five address bits)
	localparam logic [4:0] LOC_PAR_A_DATA = 5'h08;
	localparam logic [4:0] LOC_PAR_B_DATA = 5'h09;
	localparam logic [4:0] LOC_PAR_STATUS = 5'h0A;
	localparam logic [4:0] LOC_CTL_LINE_ZERO = 5'h18;
	localparam logic [4:0] LOC_CTL_LINE_FOUR = 5'h1C;
	localparam logic [4:0] LOC_CTL_LINE_FIVE = 5'h1D;
	localparam logic [4:0] LOC_CTL_LINE_SIX = 5'h1E;
	localparam logic [4:0] LOC_CTL_LINE_SEVEN = 5'h1F;
	localparam logic [1:0] CTL_RANGE_TOP = 2'h3;
	// Status register bit positions
	localparam int ST_A_FULL = 0;
	localparam int ST_A_DONE = 1;
	localparam int ST_B_FULL = 2;
	localparam int ST_B_DONE = 3;
	// Pair polarity select field layout
	localparam int PS_STB_LO = 0;
	localparam int PS_STB_HI = 1;
	localparam int PS_TAKEN_HIGH = 2;
	localparam int PS_OSTB_POS = 3;
	localparam int PS_ACK_LO = 4;
	localparam int PS_ACK_HI = 5;
	// Input strobe modes
	localparam logic [1:0] STB_POS_FALL = 2'h0;
	localparam logic [1:0] STB_NEG_RISE = 2'h1;
	localparam logic [1:0] STB_PASS = 2'h2;
	// Output acknowledge modes
	localparam logic [1:0] ACK_HIGH = 2'h0;
	localparam logic [1:0] ACK_LOW = 2'h1;
	localparam logic [1:0] ACK_NONE = 2'h2;
	// Reset values and unmapped read data
	localparam logic [7:0] OUT_DATA_RST = 8'h00;
	localparam logic [7:0] CTL_DRIVE_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int OUT_STROBE_NS = 500;
	localparam int OUT_STROBE_CYC = (OUT_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: par_pair.sv */
// One parallel port pair: output port with strobe and acknowledge, input port with latch
`timescale 1ns/100ps
module par_pair
	import vio_pkg::*;
#(
	parameter int STROBE_CYC = OUT_STROBE_CYC
) (
	input wire logic core_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic [5:0] polarity_sel, // Pair polarity select
	input wire logic host_load, // Host write to output port
	input wire logic host_read, // Host read of input port
	input wire logic [7:0] host_wdata, // Byte from host
	output logic [7:0] out_port_data, // Output port pins
	output logic out_port_strobe, // Outbound strobe pin
	input wire logic out_port_ack_in, // Peripheral acknowledge pin
	input wire logic [7:0] in_port_data, // Input port pins
	input wire logic in_port_strobe, // Peripheral strobe pin
	output logic in_port_taken, // Taken pin to peripheral
	output logic [7:0] in_byte, // Byte seen by host
	output logic input_full_flag, // Input data waiting
	output logic output_done_flag // Output acknowledged
);
	initial begin
		if (STROBE_CYC < 1 || STROBE_CYC > 255) $error("STROBE_CYC out of range");
	end
	logic [7:0] latch_r;
	logic [7:0] stb_cnt_r, stb_cnt_nxt;
	logic stb_prev_r, ack_prev_r, armed_r, taken_r, full_r, done_r;
	wire [1:0] stb_mode = polarity_sel[PS_STB_HI:PS_STB_LO];
	wire [1:0] ack_mode = polarity_sel[PS_ACK_HI:PS_ACK_LO];
	wire stb_act = (stb_mode == STB_NEG_RISE) ? ~in_port_strobe : in_port_strobe;
	// Previous levels are kept as active levels, so reset means inactive for either polarity
	wire stb_act_prev = stb_prev_r;
	wire latch_now = (stb_mode != STB_PASS) && stb_act_prev && !stb_act;
	wire stb_begin = (stb_mode != STB_PASS) && !stb_act_prev && stb_act;
	wire ack_act = (ack_mode == ACK_LOW) ? ~out_port_ack_in : out_port_ack_in;
	wire ack_act_prev = ack_prev_r;
	wire ack_seen = (ack_mode == ACK_NONE) ? 1'b1 : (ack_act && !ack_act_prev);
	wire strobing = (stb_cnt_r != 8'h00);
	wire done_set = armed_r && !strobing && ack_seen;
	assign stb_cnt_nxt = host_load ? 8'(STROBE_CYC) : (strobing ? stb_cnt_r - 8'h01 : 8'h00);
	assign out_port_strobe = polarity_sel[PS_OSTB_POS] ? strobing : ~strobing;
	assign in_port_taken = polarity_sel[PS_TAKEN_HIGH] ? taken_r : ~taken_r;
	assign in_byte = (stb_mode == STB_PASS) ? in_port_data : latch_r;
	assign input_full_flag = full_r;
	assign output_done_flag = done_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			out_port_data <= OUT_DATA_RST;
			latch_r <= 8'h00;
			stb_cnt_r <= 8'h00;
			stb_prev_r <= 1'b0;
			ack_prev_r <= 1'b0;
			armed_r <= 1'b0;
			taken_r <= 1'b1;
			full_r <= 1'b0;
			done_r <= 1'b1;
		end else begin
			if (host_load) out_port_data <= host_wdata;
			if (latch_now) latch_r <= in_port_data;
			stb_cnt_r <= stb_cnt_nxt;
			stb_prev_r <= stb_act;
			ack_prev_r <= ack_act;
			armed_r <= host_load | (armed_r & ~done_set);
			taken_r <= host_read | (taken_r & ~stb_begin);
			full_r <= latch_now | (full_r & ~host_read);
			done_r <= done_set | (done_r & ~host_load);
		end
	end
endmodule // par_pair

/* File: ctl_lines.sv */
// Eight inverted open-collector control lines
`timescale 1ns/100ps
module ctl_lines
	import vio_pkg::*;
(
	input wire logic core_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic wr_en, // Host write to a line
	input wire logic [2:0] line_sel, // Line number
	input wire logic wr_bit, // Data bit 0 from host
	input wire logic [7:0] driver_connect_switches, // Driver connected per line
	input wire logic [7:0] ctl_line_in, // Line levels
	output logic [7:0] ctl_line_out, // Driven level when enabled
	output logic [7:0] ctl_line_oe_n, // Low while pulling the line
	output logic rd_bit, // Inverted level of selected line
	output logic [7:0] drive_state // Driver latches
);
	logic [7:0] drive_r;
	assign ctl_line_out = 8'h00;
	assign ctl_line_oe_n = ~(drive_r & driver_connect_switches);
	assign rd_bit = ~ctl_line_in[line_sel];
	assign drive_state = drive_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			drive_r <= CTL_DRIVE_RST;
		end else if (wr_en) begin
			drive_r[line_sel] <= wr_bit;
		end
	end
endmodule // ctl_lines

/* File: vio_top.sv */
// Bus board decode, wait state, two parallel port pairs and eight control lines
//
// Contract
// - Claim 32 consecutive locations; low five address bits pick the location.
// - 8-bit I/O mode matches address bits 5-7 only, high bits ignored.
// - Extended I/O also matches address bits 8-15 against high select.
// - Memory mapping decodes memory cycles, matching like extended I/O.
// - With wait selected, request exactly one wait state per access.
// - Output port pulses its strobe whenever the host loads it.
// - Peripheral strobes input data; device latches the byte on the strobe.
// - Input port drives taken after host reads the latched byte.
// - Input strobe: positive falling, negative rising, or pass-through ignoring strobe.
// - Taken polarity selectable: high or low after host read.
// - Output strobe positive or negative, data valid at its trailing edge.
// - Acknowledge active-high, active-low or unused; unused means no waiting.
// - Eight single-bit active-low control lines; lines 4-7 at top four locations.
// - Control-line read returns present line state, driver connected or not.
// - Control-line access inverted: write 1 pulls low, low reads 1.
// - Open-collector driver connection per line; disconnected line is receive-only.
// - All control-line drivers released after power on.
// - Control-line accesses use data bit 0 only; others ignored.
// - Input-full flag set on peripheral delivery, cleared by host read.
// - Output-done flag set on acknowledge after load, cleared by next load.
`timescale 1ns/100ps
module vio_top
	import vio_pkg::*;
#(
	parameter int STROBE_CYC = OUT_STROBE_CYC
) (
	input wire logic core_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic [15:0] bus_addr, // Address
	input wire logic bus_io, // I/O cycle
	input wire logic bus_mem, // Memory cycle
	input wire logic bus_rd, // Read request
	input wire logic bus_wr, // Write request
	input wire logic [7:0] bus_wdata, // Write data
	output logic [7:0] bus_rdata, // Read data
	output logic bus_rvalid, // Read data valid pulse
	output logic bus_sel, // Board selected
	output logic bus_wait, // Wait state request
	input wire logic [2:0] base_address_select, // Address bits 7..5
	input wire logic map_extended, // Extended 16-bit I/O
	input wire logic map_memory, // Memory mapped
	input wire logic [7:0] high_address_select, // Address bits 15..8
	input wire logic wait_insert_select, // Insert one wait state
	input wire logic [5:0] pair_a_polarity_select, // Pair A polarities
	input wire logic [5:0] pair_b_polarity_select, // Pair B polarities
	output logic [7:0] out_a_data, // Pair A output byte
	output logic out_port_strobe_a, // Pair A outbound strobe
	input wire logic out_port_ack_in_a, // Pair A acknowledge
	input wire logic [7:0] in_a_data, // Pair A input byte
	input wire logic in_port_strobe_a, // Pair A inbound strobe
	output logic in_port_taken_a, // Pair A taken
	output logic [7:0] out_b_data, // Pair B output byte
	output logic out_port_strobe_b, // Pair B outbound strobe
	input wire logic out_port_ack_in_b, // Pair B acknowledge
	input wire logic [7:0] in_b_data, // Pair B input byte
	input wire logic in_port_strobe_b, // Pair B inbound strobe
	output logic in_port_taken_b, // Pair B taken
	input wire logic [7:0] driver_connect_switches, // Control driver connects
	input wire logic [7:0] ctl_line_in, // Control line levels
	output logic [7:0] ctl_line_out, // Control line drive level
	output logic [7:0] ctl_line_oe_n // Control line pull enable, low active
);
	initial begin
		if (STROBE_CYC < 1 || STROBE_CYC > 255) $error("STROBE_CYC out of range");
	end

	function automatic logic loc_is_ctl(input logic [4:0] loc);
		return loc[4:3] == CTL_RANGE_TOP;
	endfunction

	logic wait_done_r, wait_done_nxt;
	logic [7:0] rdata_nxt;
	logic [7:0] a_in_byte, b_in_byte, drive_state;
	logic a_full, a_done, b_full, b_done, ctl_rd_bit;

	// Address decode
	wire [4:0] loc = bus_addr[4:0];
	wire space_ok = map_memory ? bus_mem : bus_io;
	wire base_ok = bus_addr[7:5] == base_address_select;
	wire high_used = map_memory | map_extended;
	wire high_ok = high_used ? (bus_addr[15:8] == high_address_select) : 1'b1;
	wire hit = space_ok & base_ok & high_ok & (bus_rd | bus_wr);
	assign bus_sel = hit;
	assign bus_wait = hit & wait_insert_select & ~wait_done_r;
	wire accept = hit & ~bus_wait;
	wire rd_acc = accept & bus_rd;
	wire wr_acc = accept & bus_wr & ~bus_rd;
	assign wait_done_nxt = accept ? 1'b0 : bus_wait;

	// Location strobes
	wire a_load = wr_acc & (loc == LOC_PAR_A_DATA);
	wire b_load = wr_acc & (loc == LOC_PAR_B_DATA);
	wire a_read = rd_acc & (loc == LOC_PAR_A_DATA);
	wire b_read = rd_acc & (loc == LOC_PAR_B_DATA);
	wire ctl_wr = wr_acc & loc_is_ctl(loc);
	wire [7:0] status = {4'h0, b_done, b_full, a_done, a_full};

	// Read data select; unmapped returns a constant and touches nothing
	always_comb begin
		if (loc == LOC_PAR_A_DATA) begin
			rdata_nxt = a_in_byte;
		end else if (loc == LOC_PAR_B_DATA) begin
			rdata_nxt = b_in_byte;
		end else if (loc == LOC_PAR_STATUS) begin
			rdata_nxt = status;
		end else if (loc_is_ctl(loc)) begin
			rdata_nxt = {7'h00, ctl_rd_bit};
		end else begin
			rdata_nxt = UNMAPPED_RDATA;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wait_done_r <= 1'b0;
			bus_rdata <= RDATA_RST;
			bus_rvalid <= 1'b0;
		end else begin
			wait_done_r <= wait_done_nxt;
			bus_rvalid <= rd_acc;
			if (rd_acc) bus_rdata <= rdata_nxt;
		end
	end

	par_pair #(.STROBE_CYC(STROBE_CYC)) u_pair_a (
		.core_clk(core_clk),
		.rst(rst),
		.polarity_sel(pair_a_polarity_select),
		.host_load(a_load),
		.host_read(a_read),
		.host_wdata(bus_wdata),
		.out_port_data(out_a_data),
		.out_port_strobe(out_port_strobe_a),
		.out_port_ack_in(out_port_ack_in_a),
		.in_port_data(in_a_data),
		.in_port_strobe(in_port_strobe_a),
		.in_port_taken(in_port_taken_a),
		.in_byte(a_in_byte),
		.input_full_flag(a_full),
		.output_done_flag(a_done)
	);

	par_pair #(.STROBE_CYC(STROBE_CYC)) u_pair_b (
		.core_clk(core_clk),
		.rst(rst),
		.polarity_sel(pair_b_polarity_select),
		.host_load(b_load),
		.host_read(b_read),
		.host_wdata(bus_wdata),
		.out_port_data(out_b_data),
		.out_port_strobe(out_port_strobe_b),
		.out_port_ack_in(out_port_ack_in_b),
		.in_port_data(in_b_data),
		.in_port_strobe(in_port_strobe_b),
		.in_port_taken(in_port_taken_b),
		.in_byte(b_in_byte),
		.input_full_flag(b_full),
		.output_done_flag(b_done)
	);

	ctl_lines u_ctl (
		.core_clk(core_clk),
		.rst(rst),
		.wr_en(ctl_wr),
		.line_sel(loc[2:0]),
		.wr_bit(bus_wdata[0]),
		.driver_connect_switches(driver_connect_switches),
		.ctl_line_in(ctl_line_in),
		.ctl_line_out(ctl_line_out),
		.ctl_line_oe_n(ctl_line_oe_n),
		.rd_bit(ctl_rd_bit),
		.drive_state(drive_state)
	);

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	wire req8 = bus_io & ~map_memory & ~map_extended & (bus_rd | bus_wr);

	property p_sel_eight;
		req8 && bus_addr[7:5] == base_address_select |-> bus_sel;
	endproperty
	a_sel_eight: assert property (p_sel_eight) else $error("8-bit decode missed");

	property p_sel_high;
		map_extended && !map_memory && bus_addr[15:8] != high_address_select |-> !bus_sel;
	endproperty
	a_sel_high: assert property (p_sel_high) else $error("high bits not matched");

	property p_mem_space;
		map_memory && !bus_mem |-> !bus_sel;
	endproperty
	a_mem_space: assert property (p_mem_space) else $error("memory mode took non-memory");

	sequence s_new_hit;
		bus_sel && !$past(bus_sel);
	endsequence
	property p_one_wait;
		s_new_hit and wait_insert_select |-> bus_wait ##1 (!bus_wait || !bus_sel);
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");

	property p_no_wait;
		!wait_insert_select |-> !bus_wait;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("unwanted wait state");

	sequence s_load_a;
		a_load ##1 1'b1;
	endsequence
	property p_strobe_a;
		s_load_a |-> out_port_strobe_a == pair_a_polarity_select[PS_OSTB_POS]
			&& out_a_data == $past(bus_wdata);
	endproperty
	a_strobe_a: assert property (p_strobe_a) else $error("output strobe or data missing");

	property p_ctl_read;
		rd_acc && loc_is_ctl(loc) |=> bus_rvalid
			&& bus_rdata == {7'h00, ~$past(ctl_line_in[loc[2:0]])};
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control line read wrong");

	property p_ctl_drive;
		ctl_wr && bus_wdata[0] && driver_connect_switches[loc[2:0]]
			|=> !ctl_line_oe_n[$past(loc[2:0])];
	endproperty
	a_ctl_drive: assert property (p_ctl_drive) else $error("control line not pulled");

	property p_ctl_recv_only;
		1'b1 |-> (ctl_line_oe_n | driver_connect_switches) == 8'hFF;
	endproperty
	a_ctl_recv_only: assert property (p_ctl_recv_only) else $error("disconnected line driven");

	property p_power_on;
		$past(rst) |-> drive_state == CTL_DRIVE_RST && ctl_line_oe_n == 8'hFF;
	endproperty
	a_power_on: assert property (p_power_on) else $error("drivers not released at reset");

	property p_read_clears_full;
		a_read && !(pair_a_polarity_select[PS_STB_HI:PS_STB_LO] != STB_PASS
			&& in_port_strobe_a != $past(in_port_strobe_a)) |=> !a_full;
	endproperty
	a_read_clears_full: assert property (p_read_clears_full) else $error("full flag stuck");

	property p_load_clears_done;
		a_load |=> !a_done [*2];
	endproperty
	a_load_clears_done: assert property (p_load_clears_done) else $error("done flag stuck");

	property p_unused_quiet;
		rd_acc && rdata_nxt == UNMAPPED_RDATA && !loc_is_ctl(loc) && loc != LOC_PAR_A_DATA
			&& loc != LOC_PAR_B_DATA && loc != LOC_PAR_STATUS
			|=> $stable(drive_state) && $stable(out_a_data) && $stable(out_b_data);
	endproperty
	a_unused_quiet: assert property (p_unused_quiet) else $error("unused read changed state");

	// Bus and parallel port checks
	property p_wait_release;
		bus_wait |=> !bus_wait;
	endproperty
	a_wait_release: assert property (p_wait_release) else $error("wait state too long");

	property p_unsel_quiet;
		!bus_sel |=> $stable(drive_state) && !bus_rvalid;
	endproperty
	a_unsel_quiet: assert property (p_unsel_quiet) else $error("unselected cycle acted");

	property p_strobe_b;
		b_load |=> out_port_strobe_b == pair_b_polarity_select[PS_OSTB_POS]
			&& out_b_data == $past(bus_wdata);
	endproperty
	a_strobe_b: assert property (p_strobe_b) else $error("strobe B missing");

	property p_out_hold;
		!a_load && !b_load |=> $stable(out_a_data) && $stable(out_b_data);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output byte changed");

	property p_taken_a;
		a_read |=> in_port_taken_a == pair_a_polarity_select[PS_TAKEN_HIGH];
	endproperty
	a_taken_a: assert property (p_taken_a) else $error("taken A not shown");

	property p_taken_b;
		b_read |=> in_port_taken_b == pair_b_polarity_select[PS_TAKEN_HIGH];
	endproperty
	a_taken_b: assert property (p_taken_b) else $error("taken B not shown");

	property p_taken_drop_a;
		pair_a_polarity_select[PS_STB_HI:PS_STB_LO] == STB_POS_FALL
			&& $rose(in_port_strobe_a) && !a_read |=> in_port_taken_a != pair_a_polarity_select[PS_TAKEN_HIGH];
	endproperty
	a_taken_drop_a: assert property (p_taken_drop_a) else $error("taken A not dropped");

	property p_full_set_a;
		pair_a_polarity_select[PS_STB_HI:PS_STB_LO] == STB_POS_FALL
			&& $fell(in_port_strobe_a) |=> a_full;
	endproperty
	a_full_set_a: assert property (p_full_set_a) else $error("full A not set");

	property p_full_set_b;
		pair_b_polarity_select[PS_STB_HI:PS_STB_LO] == STB_NEG_RISE
			&& $rose(in_port_strobe_b) |=> b_full;
	endproperty
	a_full_set_b: assert property (p_full_set_b) else $error("full B not set");

	property p_pass_no_full;
		pair_a_polarity_select[PS_STB_HI:PS_STB_LO] == STB_PASS && !a_full |=> !a_full;
	endproperty
	a_pass_no_full: assert property (p_pass_no_full) else $error("pass mode set full");

	property p_pass_read;
		pair_a_polarity_select[PS_STB_HI:PS_STB_LO] == STB_PASS && a_read
			|=> bus_rdata == $past(in_a_data);
	endproperty
	a_pass_read: assert property (p_pass_read) else $error("pass mode read wrong");

	property p_done_needs_ack;
		pair_a_polarity_select[PS_ACK_HI:PS_ACK_LO] == ACK_HIGH && !a_done
			&& !$rose(out_port_ack_in_a) |=> !a_done;
	endproperty
	a_done_needs_ack: assert property (p_done_needs_ack) else $error("done without ack");

	property p_status_map;
		rd_acc && loc == LOC_PAR_STATUS
			|=> bus_rdata == {4'h0, $past(b_done), $past(b_full), $past(a_done), $past(a_full)};
	endproperty
	a_status_map: assert property (p_status_map) else $error("status read wrong");

	// Control line checks
	property p_ctl_release;
		ctl_wr && !bus_wdata[0] |=> ctl_line_oe_n[$past(loc[2:0])];
	endproperty
	a_ctl_release: assert property (p_ctl_release) else $error("control line not released");

	property p_ctl_range;
		wr_acc && !loc_is_ctl(loc) |=> $stable(drive_state);
	endproperty
	a_ctl_range: assert property (p_ctl_range) else $error("control line hit outside range");

endmodule // vio_top

/* File: periph.sv */
// Peripheral model on the parallel port side of both pairs
`timescale 1ns/100ps
module periph (
	input wire logic core_clk, // Clock
	input wire logic ostb_a, // Pair A outbound strobe, active high
	output logic ack_a, // Pair A acknowledge, active high
	output logic ack_b, // Pair B acknowledge, port ignores it
	output logic [7:0] din_a, // Pair A input pins
	output logic [7:0] din_b, // Pair B input pins
	output logic stb_a, // Pair A inbound strobe, active high
	output logic stb_b // Pair B inbound strobe, active low
);
	initial begin
		ack_a = 1'b0;
		ack_b = 1'b0;
		din_a = 8'h00;
		din_b = 8'h00;
		stb_a = 1'b0;
		stb_b = 1'b1;
	end
	// Answers slowly: acknowledge comes well after the strobe's trailing edge
	always begin
		@(negedge ostb_a);
		repeat (5) @(posedge core_clk);
		ack_a <= 1'b1;
		repeat (2) @(posedge core_clk);
		ack_a <= 1'b0;
	end
	// Pins change to the inverse once the byte's hold time has run out
	task push(input logic p, input logic [7:0] d);
		@(posedge core_clk);
		if (!p) begin
			din_a <= d;
			stb_a <= 1'b1;
		end else begin
			din_b <= d;
			stb_b <= 1'b0;
		end
		repeat (3) @(posedge core_clk);
		if (!p) stb_a <= 1'b0;
		else stb_b <= 1'b1;
		@(posedge core_clk);
		if (!p) din_a <= ~d;
		else din_b <= ~d;
	endtask
endmodule // periph

/* File: vio_top_tb.sv */
// Self-checking testbench for the bus board parallel and control-line block
`timescale 1ns/100ps
module vio_top_tb
	import vio_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] bus_addr = 16'h0000;
	logic bus_io = 1'b0, bus_mem = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
	logic [7:0] bus_wdata = 8'h00;
	logic [2:0] base = 3'h5;
	logic m_ext = 1'b0, m_mem = 1'b0, w_sel = 1'b1, hit, memcyc = 1'b0;
	logic [7:0] hi = 8'hA5, sw = 8'h0F, ext = 8'h5A, q;
	logic [5:0] pol_a = 6'h0C, pol_b = 6'h21;
	wire [7:0] bus_rdata, out_a, out_b, din_a, din_b, ctl_out, oe_n, ctl_in;
	wire bus_rvalid, bus_sel, bus_wait, ostb_a, ostb_b, ack_a, ack_b;
	wire istb_a, istb_b, tk_a, tk_b;
	int n_mismatch = 0, checks = 0, nwait;
	// Open-collector wire: other parties hold the pattern in ext
	assign ctl_in = ext & oe_n;
	always #25 core_clk = ~core_clk;
	vio_top #(.STROBE_CYC(2)) i_dut (.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr),
		.bus_io(bus_io), .bus_mem(bus_mem), .bus_rd(bus_rd), .bus_wr(bus_wr),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
		.bus_sel(bus_sel), .bus_wait(bus_wait), .base_address_select(base),
		.map_extended(m_ext), .map_memory(m_mem), .high_address_select(hi),
		.wait_insert_select(w_sel), .pair_a_polarity_select(pol_a),
		.pair_b_polarity_select(pol_b), .out_a_data(out_a), .out_port_strobe_a(ostb_a),
		.out_port_ack_in_a(ack_a), .in_a_data(din_a), .in_port_strobe_a(istb_a),
		.in_port_taken_a(tk_a), .out_b_data(out_b), .out_port_strobe_b(ostb_b),
		.out_port_ack_in_b(ack_b), .in_b_data(din_b), .in_port_strobe_b(istb_b),
		.in_port_taken_b(tk_b), .driver_connect_switches(sw), .ctl_line_in(ctl_in),
		.ctl_line_out(ctl_out), .ctl_line_oe_n(oe_n));
	periph i_per (.core_clk(core_clk), .ostb_a(ostb_a), .ack_a(ack_a), .ack_b(ack_b),
		.din_a(din_a), .din_b(din_b), .stb_a(istb_a), .stb_b(istb_b));
	task stop_test;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Holds the request until the edge where it is accepted
	task bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
		int k;
		logic ok;
		ok = 1'b0;
		nwait = 0;
		@(posedge core_clk);
		bus_addr <= a;
		bus_wr <= wr;
		bus_rd <= !wr;
		bus_wdata <= d;
		bus_io <= !memcyc;
		bus_mem <= memcyc;
		for (k = 0; k < 6; k++) begin
			@(negedge core_clk);
			if (bus_sel !== 1'b1) k = 6;
			else if (bus_wait === 1'b1) nwait++;
			else begin
				ok = 1'b1;
				k = 6;
			end
		end
		if (!ok && bus_sel === 1'b1) begin
			n_mismatch++;
			stop_test;
		end
		hit = ok;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		bus_wr <= 1'b0;
		@(negedge core_clk);
		if (ok && !wr) begin
			chk({7'h0, bus_rvalid}, 8'h01);
			q = bus_rdata;
		end
	endtask
	task w(input logic [4:0] l, input logic [7:0] d);
		bus(1'b1, {hi, base, l}, d);
	endtask
	task r(input logic [4:0] l);
		bus(1'b0, {hi, base, l}, 8'h00);
	endtask
	task t_reset;
		chk(oe_n, 8'hFF);
		chk({4'h0, ostb_a, ostb_b, tk_a, tk_b}, 8'h06);
		chk(out_a, OUT_DATA_RST);
		r(LOC_PAR_STATUS);
		chk(q, 8'h0A);
	endtask
	task t_decode;
		bus(1'b0, 16'hFFBC, 8'h00);
		chk({7'h0, hit}, 8'h01);
		chk(nwait[7:0], 8'h01);
		chk(q, 8'h00);
		bus(1'b0, 16'hFFDC, 8'h00);
		chk({7'h0, hit}, 8'h00);
		@(posedge core_clk);
		m_ext <= 1'b1;
		bus(1'b0, 16'hFFBC, 8'h00);
		chk({7'h0, hit}, 8'h00);
		bus(1'b0, 16'hA4BC, 8'h00);
		chk({7'h0, hit}, 8'h00);
		bus(1'b0, 16'hA5BC, 8'h00);
		chk({7'h0, hit}, 8'h01);
		@(posedge core_clk);
		m_mem <= 1'b1;
		bus(1'b0, 16'hA5BC, 8'h00);
		chk({7'h0, hit}, 8'h00);
		memcyc = 1'b1;
		bus(1'b0, 16'hA4BC, 8'h00);
		chk({7'h0, hit}, 8'h00);
		@(posedge core_clk);
		w_sel <= 1'b0;
		bus(1'b0, 16'hA5BC, 8'h00);
		chk({7'h0, hit}, 8'h01);
		chk(nwait[7:0], 8'h00);
		memcyc = 1'b0;
		@(posedge core_clk);
		m_ext <= 1'b0;
		m_mem <= 1'b0;
		w_sel <= 1'b1;
	endtask
	task t_ctl;
		int i;
		for (i = 0; i < 8; i++) begin
			w(5'(LOC_CTL_LINE_ZERO + i), 8'hFF);
			chk({7'h0, oe_n[i]}, {7'h0, ~sw[i]});
			r(5'(LOC_CTL_LINE_ZERO + i));
			chk(q, {7'h0, ~(ext[i] & ~sw[i])});
			w(5'(LOC_CTL_LINE_ZERO + i), 8'hFE);
			chk({7'h0, oe_n[i]}, 8'h01);
			r(5'(LOC_CTL_LINE_ZERO + i));
			chk(q, {7'h0, ~ext[i]});
		end
	endtask
	task t_out;
		w(LOC_PAR_A_DATA, 8'h3C);
		@(negedge core_clk);
		chk({7'h0, ostb_a}, 8'h01);
		@(negedge core_clk);
		chk({7'h0, ostb_a}, 8'h00);
		r(LOC_PAR_STATUS);
		chk(q & 8'h02, 8'h00);
		w(LOC_PAR_B_DATA, 8'hC3);
		@(negedge core_clk);
		chk({7'h0, ostb_b}, 8'h00);
		@(negedge core_clk);
		chk({7'h0, ostb_b}, 8'h01);
		repeat (12) @(posedge core_clk);
		r(LOC_PAR_STATUS);
		chk(q, 8'h0A);
		chk(out_a, 8'h3C);
		chk(out_b, 8'hC3);
	endtask
	task t_in;
		i_per.push(1'b0, 8'h96);
		chk({6'h0, tk_a, tk_b}, 8'h00);
		r(LOC_PAR_STATUS);
		chk(q & 8'h05, 8'h01);
		r(LOC_PAR_A_DATA);
		chk(q, 8'h96);
		chk({7'h0, tk_a}, 8'h01);
		i_per.push(1'b1, 8'h69);
		chk({7'h0, tk_b}, 8'h01);
		r(LOC_PAR_B_DATA);
		chk(q, 8'h69);
		chk({7'h0, tk_b}, 8'h00);
		r(LOC_PAR_B_DATA);
		chk(q, 8'h69);
		r(LOC_PAR_STATUS);
		chk(q & 8'h05, 8'h00);
		@(posedge core_clk);
		pol_a <= 6'h0E;
		i_per.push(1'b0, 8'h5A);
		r(LOC_PAR_STATUS);
		chk(q & 8'h05, 8'h00);
		r(LOC_PAR_A_DATA);
		chk(q, 8'hA5);
		@(posedge core_clk);
		pol_a <= 6'h0C;
	endtask
	task t_unmap;
		r(5'h0C);
		chk(q, UNMAPPED_RDATA);
		w(5'h03, 8'hFF);
		w(5'h0D, 8'hFF);
		r(LOC_PAR_STATUS);
		chk(q, 8'h0A);
		chk(out_a, 8'h3C);
		chk(oe_n, 8'hFF);
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset;
		t_decode;
		t_ctl;
		t_out;
		t_in;
		t_unmap;
		stop_test;
	end
endmodule // vio_top_tb
